// ### i2cbr_pkg.sv
// constants, register map and state codes for the buffered register front end
package i2cbr_pkg;
  localparam int NREG = 11;
  localparam int RB = 8;
  localparam logic [15:0] ADDR_MAX = 16'h1788;
  localparam logic [15:0] ADDR_STROBE = 16'h000f;
  localparam logic [7:0] STROBE_VAL = 8'h01;
  localparam logic [7:0] REG_RST = 8'h00;
  // implemented registers, ascending so multi-byte fields stay little endian
  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'h0100, 16'h0101, 16'h0102, 16'h0103, 16'h0104, 16'h0105,
    16'h0106, 16'h0107, 16'h0108, 16'h0109, 16'h0d00};
  // reference that each register belongs to (holdover classes only)
  localparam logic [1:0] REG_REF [NREG] = '{
    2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
  // attribute masks, bit i describes register index i
  localparam logic [NREG-1:0] M_LIVE = 11'h100;
  localparam logic [NREG-1:0] M_RO = 11'h400;
  localparam logic [NREG-1:0] M_EXCL = 11'h101;
  localparam logic [NREG-1:0] M_AC = 11'h200;
  localparam logic [NREG-1:0] M_W1 = 11'h001;
  localparam logic [NREG-1:0] M_W2 = 11'h006;
  localparam logic [NREG-1:0] M_W3 = 11'h009;
  localparam logic [NREG-1:0] M_W5 = 11'h010;
  localparam logic [NREG-1:0] M_W6 = 11'h020;
  localparam logic [NREG-1:0] M_W7 = 11'h040;
  localparam logic [NREG-1:0] M_W8 = 11'h080;
  localparam logic [3:0] AC_IDX = 4'h9;
  // i2c byte framing
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] PH_HI = 2'h0;
  localparam logic [1:0] PH_LO = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_RX = 6'h04,
    S_ACKT = 6'h08,
    S_TX = 6'h10,
    S_ACKR = 6'h20
  } i2cbr_state_t;
endpackage

// ### i2cbr_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module i2cbr_sync3 #(
  parameter logic INIT = 1'h1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pin in, filtered level out
  input wire logic raw,
  output logic lvl
);
  logic ff1_q, ff2_q, ff3_q, lvl_d;

  // the level only moves once stages two and three agree
  always_comb begin
    lvl_d = lvl;
    if (ff2_q == ff3_q) begin
      lvl_d = ff3_q;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ff1_q <= INIT;
      ff2_q <= INIT;
      ff3_q <= INIT;
      lvl <= INIT;
    end else begin
      ff1_q <= raw;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      lvl <= lvl_d;
    end
  end
endmodule

// ### i2cbr_top.sv
// i2c slave with buffered/active register bank and write-detect effects
// Operation
// - write: address high, low, then data bytes
// - address-only write just loads pointer
// - read returns bytes from pointer until nack
// - combined read via repeated start supported
// - register space limited to 0x0000..0x1788
// - lowest address holds least significant bits
// - writing 0x01 to 0x000f copies buffered
// - live registers take effect on write
// - class two write: holdover at strobe
// - class three write drops loop lock
// - class five write holds watchdog until strobe
// - class six change resets stability timer
// - class seven write stops function until strobe
// - class eight like two, demap mode only
// - autoclear acts after strobe, cleared when done
// - multiple classes: effects of every class combine
// - denied or unmapped: read zero, ignore write
// - eeprom active owns regular registers
// - read-only always serial readable, never eeprom
// - excluded registers never touched by eeprom
// - direction bit: zero write, one read
// - sixteen-bit register address in two bytes
// - nack at ninth clock returns idle
// - start or stop resynchronises, drops partial
`timescale 1ns/100ps
module i2cbr_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // two-wire port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] slave_addr,
  // eeprom controller side
  input wire logic eeprom_busy,
  input wire logic [15:0] eeprom_addr,
  input wire logic eeprom_we,
  input wire logic [7:0] eeprom_wdata,
  output logic [7:0] eeprom_rdata,
  // device state inputs
  input wire logic [1:0] selected_ref,
  input wire logic demap_mode,
  input wire logic system_clock_locked,
  input wire logic phase_detector_cycle,
  input wire logic action_done,
  // active copies and write-detect effects
  output logic [i2cbr_pkg::NREG*i2cbr_pkg::RB-1:0] active_regs,
  output logic lock_unlock,
  output logic loop_unlock,
  output logic holdover,
  output logic watchdog_hold,
  output logic stab_timer_run,
  output logic func_stop
);
  import i2cbr_pkg::*;

  logic scl_f, sda_f, scl_p, sda_p;
  logic scl_rise, scl_fall, start_c, stop_c;
  i2cbr_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic rw_q, rw_d, oe_d;
  logic [15:0] ptr_q, ptr_d;
  logic ser_wr;
  logic [7:0] rd_c;
  logic [NREG*RB-1:0] buf_q, buf_d, act_d;
  logic lock_d, loopu_d, hold_d, pend_q, pend_d;
  logic wd_d, stab_q, stab_d, run_d, fstop_d;
  logic [7:0] erd_d, status_c;
  logic strobe, wr_ok, e_ok;
  logic [4:0] wfind, efind;
  logic [3:0] widx, eidx;

  i2cbr_sync3 #(.INIT(1'h1)) u_scl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .raw(scl), .lvl(scl_f));
  i2cbr_sync3 #(.INIT(1'h1)) u_sda (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .raw(sda_in), .lvl(sda_f));

  // {hit, index}; anything outside the table or above the top is unmapped
  function automatic logic [4:0] reg_find(input logic [15:0] a);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < NREG; i++) begin
      if (a <= ADDR_MAX && a == REG_ADDR[i]) begin
        r = {1'h1, i[3:0]};
      end
    end
    return r;
  endfunction

  assign status_c = {2'h0, eeprom_busy, stab_timer_run, func_stop,
    watchdog_hold, holdover, lock_unlock};

  // serial read view: read-only stays visible during eeprom activity
  always_comb begin
    logic [4:0] f;
    f = reg_find(ptr_q);
    rd_c = 8'h00;
    if (f[4] && M_RO[f[3:0]]) begin
      rd_c = status_c;
    end else if (f[4] && !eeprom_busy) begin
      rd_c = buf_q[{f[3:0], 3'h0} +: RB];
    end
  end

  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_c = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_c = scl_f & scl_p & ~sda_p & sda_f;

  // two-wire engine
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    rw_d = rw_q;
    ptr_d = ptr_q;
    oe_d = sda_oe;
    ser_wr = 1'h0;
    if (start_c) begin
      st_d = S_ADDR;
      cnt_d = '0;
      ph_d = PH_HI;
      oe_d = 1'h0;
    end else if (stop_c) begin
      st_d = S_IDLE;
      oe_d = 1'h0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          oe_d = 1'h0;
        end
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_BYTE) begin
            cnt_d = '0;
            if (st_q == S_ADDR) begin
              if (sh_q[7:1] == slave_addr) begin
                rw_d = sh_q[0];
                oe_d = 1'h1;
                st_d = S_ACKT;
              end else begin
                st_d = S_IDLE;
              end
            end else begin
              oe_d = 1'h1;
              st_d = S_ACKT;
              unique case (ph_q)
                PH_HI: begin
                  ptr_d[15:8] = sh_q;
                  ph_d = PH_LO;
                end
                PH_LO: begin
                  ptr_d[7:0] = sh_q;
                  ph_d = PH_DATA;
                end
                default: begin
                  ser_wr = 1'h1;
                  ptr_d = ptr_q + 16'h0001;
                end
              endcase
            end
          end
        end
        S_ACKT, S_ACKR: begin
          if (st_q == S_ACKR && scl_rise && sda_f) begin
            st_d = S_IDLE;
          end else if (scl_fall) begin
            if (rw_q) begin
              sh_d = rd_c;
              ptr_d = ptr_q + 16'h0001;
              oe_d = ~rd_c[7];
              st_d = S_TX;
            end else begin
              oe_d = 1'h0;
              st_d = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == LAST_BIT) begin
              oe_d = 1'h0;
              cnt_d = '0;
              st_d = S_ACKR;
            end else begin
              sh_d = {sh_q[6:0], 1'h0};
              cnt_d = cnt_q + 4'h1;
              oe_d = ~sh_q[6];
            end
          end
        end
        default: begin
          st_d = S_IDLE;
          oe_d = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p <= 1'h1;
      sda_p <= 1'h1;
      st_q <= S_IDLE;
      sh_q <= '0;
      cnt_q <= '0;
      ph_q <= PH_HI;
      rw_q <= 1'h0;
      ptr_q <= '0;
      sda_oe <= 1'h0;
      sda_out <= 1'h0;
    end else begin
      scl_p <= scl_f;
      sda_p <= sda_f;
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      rw_q <= rw_d;
      ptr_q <= ptr_d;
      sda_oe <= oe_d;
      sda_out <= 1'h0;
    end
  end

  // register bank; effects of several classes simply combine
  assign wfind = reg_find(ptr_q);
  assign widx = wfind[3:0];
  assign efind = reg_find(eeprom_addr);
  assign eidx = efind[3:0];
  // read-only beats every other class for writes
  assign wr_ok = ser_wr && wfind[4] && !M_RO[widx] && !eeprom_busy;
  assign strobe = ser_wr && ptr_q == ADDR_STROBE && sh_q == STROBE_VAL
    && !eeprom_busy;
  assign e_ok = eeprom_busy && efind[4] && !M_RO[eidx] && !M_EXCL[eidx];

  always_comb begin
    buf_d = buf_q;
    act_d = active_regs;
    lock_d = lock_unlock;
    loopu_d = 1'h0;
    hold_d = holdover;
    pend_d = pend_q;
    wd_d = watchdog_hold;
    stab_d = stab_q;
    fstop_d = func_stop;
    erd_d = 8'h00;
    if (action_done) begin
      buf_d[{AC_IDX, 3'h0} +: RB] = REG_RST;
      act_d[{AC_IDX, 3'h0} +: RB] = REG_RST;
    end
    if (phase_detector_cycle) begin
      hold_d = 1'h0;
    end
    if (strobe) begin
      // load the pre-clear copy: a same-cycle autoclear must not cancel it
      act_d = buf_q;
      lock_d = 1'h0;
      wd_d = 1'h0;
      stab_d = 1'h0;
      fstop_d = 1'h0;
      hold_d = hold_d | pend_q;
      pend_d = 1'h0;
    end
    if (wr_ok) begin
      buf_d[{widx, 3'h0} +: RB] = sh_q;
      if (M_LIVE[widx]) begin
        act_d[{widx, 3'h0} +: RB] = sh_q;
      end
      if (M_W1[widx]) begin
        lock_d = 1'h1;
      end
      if (M_W2[widx] && REG_REF[widx] == selected_ref) begin
        pend_d = 1'h1;
      end
      if (M_W8[widx] && demap_mode && REG_REF[widx] == selected_ref) begin
        pend_d = 1'h1;
      end
      if (M_W3[widx]) begin
        loopu_d = 1'h1;
      end
      if (M_W5[widx]) begin
        wd_d = 1'h1;
      end
      if (M_W6[widx] && sh_q != buf_q[{widx, 3'h0} +: RB]) begin
        stab_d = 1'h1;
      end
      if (M_W7[widx]) begin
        fstop_d = 1'h1;
      end
    end
    if (e_ok) begin
      erd_d = buf_q[{eidx, 3'h0} +: RB];
      if (eeprom_we) begin
        buf_d[{eidx, 3'h0} +: RB] = eeprom_wdata;
      end
    end
    run_d = !stab_d && system_clock_locked;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= '0;
      active_regs <= '0;
      lock_unlock <= 1'h0;
      loop_unlock <= 1'h0;
      holdover <= 1'h0;
      pend_q <= 1'h0;
      watchdog_hold <= 1'h0;
      stab_q <= 1'h0;
      stab_timer_run <= 1'h0;
      func_stop <= 1'h0;
      eeprom_rdata <= 8'h00;
    end else begin
      buf_q <= buf_d;
      active_regs <= act_d;
      lock_unlock <= lock_d;
      loop_unlock <= loopu_d;
      holdover <= hold_d;
      pend_q <= pend_d;
      watchdog_hold <= wd_d;
      stab_q <= stab_d;
      stab_timer_run <= run_d;
      func_stop <= fstop_d;
      eeprom_rdata <= erd_d;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_strobe_copy;
    strobe && !action_done |=> active_regs == $past(buf_q);
  endproperty
  a_strobe_copy: assert property (p_strobe_copy)
    else $error("strobe did not copy buffered to active");

  property p_w1_unlock;
    wr_ok && M_W1[widx] |=> lock_unlock ##1 lock_unlock;
  endproperty
  a_w1_unlock: assert property (p_w1_unlock)
    else $error("class one write did not hold unlock");

  property p_strobe_relock;
    strobe |=> !lock_unlock && !watchdog_hold && !func_stop;
  endproperty
  a_strobe_relock: assert property (p_strobe_relock)
    else $error("strobe did not release held functions");

  property p_w3_pulse;
    wr_ok && M_W3[widx] |=> loop_unlock ##1 !loop_unlock;
  endproperty
  a_w3_pulse: assert property (p_w3_pulse)
    else $error("loop unlock pulse wrong");

  property p_holdover;
    strobe && pend_q |=> holdover;
  endproperty
  a_holdover: assert property (p_holdover)
    else $error("pending holdover not entered at strobe");

  property p_hold_exit;
    holdover && phase_detector_cycle && !strobe |=> !holdover;
  endproperty
  a_hold_exit: assert property (p_hold_exit)
    else $error("holdover outlasted one detector cycle");

  property p_denied;
    ser_wr && !wr_ok && !e_ok && !action_done |=> buf_q == $past(buf_q);
  endproperty
  a_denied: assert property (p_denied)
    else $error("denied write changed a register");

  property p_nack_idle;
    st_q == S_ACKR && scl_rise && sda_f && !start_c && !stop_c
      |=> st_q == S_IDLE && !sda_oe;
  endproperty
  a_nack_idle: assert property (p_nack_idle)
    else $error("nack did not return to idle");

  property p_start_sync;
    start_c |=> st_q == S_ADDR && cnt_q == 4'h0;
  endproperty
  a_start_sync: assert property (p_start_sync)
    else $error("start did not restart framing");

  property p_ptr_inc;
    ser_wr |=> ptr_q == $past(ptr_q) + 16'h0001;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("pointer did not advance after data byte");

  property p_excl;
    eeprom_busy && efind[4] && (M_RO[eidx] || M_EXCL[eidx])
      |=> eeprom_rdata == 8'h00;
  endproperty
  a_excl: assert property (p_excl)
    else $error("eeprom saw an excluded register");

  c_strobe: cover property (strobe);
  c_read_byte: cover property (st_q == S_TX ##[1:300] st_q == S_ACKR);
  c_holdover: cover property (holdover);
  c_nack: cover property (st_q == S_ACKR ##1 st_q == S_IDLE);
endmodule

// ### i2cbr_master.sv
// i2c master model: drives scl and the open-drain data pull
`timescale 1ns/100ps
module i2cbr_master (
  // clock
  input wire logic clk_sys,
  // two-wire bus
  input wire logic sda,
  output logic scl,
  output logic m_low,
  // byte taken in a read
  output logic got_v,
  output logic [7:0] got_d
);
  initial begin
    scl = 1'h1;
    m_low = 1'h0;
    got_v = 1'h0;
    got_d = 8'h00;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // scl stands high outside frames
  task automatic start();
    if (scl == 1'h0) begin
      // the slave lets go of its ack some five clocks after scl falls
      m_low = 1'h0;
      tk(6);
      scl = 1'h1;
      tk(3);
    end
    m_low = 1'h1;
    tk(4);
    scl = 1'h0;
  endtask
  task automatic stop();
    tk(1);
    m_low = 1'h1;
    tk(4);
    scl = 1'h1;
    tk(3);
    m_low = 1'h0;
    tk(4);
  endtask
  // long low phase: slave drive lands well before the rise
  task automatic bout(input logic b);
    tk(1);
    m_low = ~b;
    tk(4);
    scl = 1'h1;
    tk(3);
    scl = 1'h0;
  endtask
  // released line floats high through the pull-up
  task automatic bin(output logic b);
    tk(1);
    m_low = 1'h0;
    tk(4);
    scl = 1'h1;
    tk(2);
    b = sda;
    tk(1);
    scl = 1'h0;
  endtask
  // msb first, direction bit is bit zero of the address byte
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bout(d[i]);
    bin(b);
    ack = ~b;
  endtask
  // last byte of a read left unacknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bin(b);
      d[i] = b;
    end
    bout(last);
    got_d = d;
    got_v = 1'h1;
    tk(1);
    got_v = 1'h0;
  endtask
endmodule

// ### i2cbr_top_tb_top.sv
// self-checking bench for the i2c buffered register front end
`timescale 1ns/100ps
module i2cbr_top_tb_top;
  import i2cbr_pkg::*;
  localparam logic [6:0] SA = 7'h4a;
  logic clk_sys, sys_rst, scl, m_low, sda, sda_out, sda_oe, got_v;
  logic eeprom_busy, eeprom_we, demap_mode, system_clock_locked;
  logic phase_detector_cycle, action_done, lock_unlock, loop_unlock;
  logic holdover, watchdog_hold, stab_timer_run, func_stop, lu_seen, k;
  logic [15:0] eeprom_addr;
  logic [7:0] eeprom_wdata, eeprom_rdata, got_d;
  logic [1:0] selected_ref;
  logic [NREG*RB-1:0] active_regs;
  logic [7:0] wd [4];
  logic [7:0] exp_q [$];
  logic [31:0] st;
  int n_fail, cmp_count;
  // wire level: pulled up, low if either party pulls
  assign sda = ~(sda_oe | m_low);
  i2cbr_top i2cbr_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr(SA),
    .eeprom_busy(eeprom_busy), .eeprom_addr(eeprom_addr),
    .eeprom_we(eeprom_we), .eeprom_wdata(eeprom_wdata),
    .eeprom_rdata(eeprom_rdata), .selected_ref(selected_ref),
    .demap_mode(demap_mode), .system_clock_locked(system_clock_locked),
    .phase_detector_cycle(phase_detector_cycle),
    .action_done(action_done), .active_regs(active_regs),
    .lock_unlock(lock_unlock), .loop_unlock(loop_unlock),
    .holdover(holdover), .watchdog_hold(watchdog_hold),
    .stab_timer_run(stab_timer_run), .func_stop(func_stop));
  i2cbr_master i2cbr_master_i (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .m_low(m_low), .got_v(got_v), .got_d(got_d));
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // oldest noted byte against each byte the master takes
  always @(posedge got_v) begin
    if (exp_q.size() == 0) chk("extra read", 8'h00, 8'hff);
    else chk("read byte", exp_q.pop_front(), got_d);
  end
  always @(posedge clk_sys)
    lu_seen <= !sys_rst && (lu_seen === 1'h1 || loop_unlock === 1'h1);
  task automatic tk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic hdr(input logic [15:0] a);
    i2cbr_master_i.start();
    i2cbr_master_i.wbyte({SA, 1'h0}, k);
    chk("ack addr", 8'h01, k);
    i2cbr_master_i.wbyte(a[15:8], k);
    chk("ack hi", 8'h01, k);
    i2cbr_master_i.wbyte(a[7:0], k);
    chk("ack lo", 8'h01, k);
  endtask
  task automatic wr(input logic [15:0] a, input int n);
    hdr(a);
    for (int i = 0; i < n; i++) begin
      i2cbr_master_i.wbyte(wd[i], k);
      chk("ack data", 8'h01, k);
    end
    i2cbr_master_i.stop();
  endtask
  task automatic rd(input logic [15:0] a, input int n, input logic c);
    logic [7:0] d;
    if (c) hdr(a);
    i2cbr_master_i.start();
    i2cbr_master_i.wbyte({SA, 1'h1}, k);
    chk("ack raddr", 8'h01, k);
    for (int i = 0; i < n; i++) i2cbr_master_i.rbyte(i == n - 1, d);
    i2cbr_master_i.stop();
  endtask
  task automatic strobe();
    logic [7:0] keep;
    keep = wd[0];
    wd[0] = STROBE_VAL;
    wr(ADDR_STROBE, 1);
    wd[0] = keep;
    tk(2);
  endtask
  task automatic pulse(input int w);
    if (w == 0) phase_detector_cycle = 1'h1;
    else action_done = 1'h1;
    tk(1);
    phase_detector_cycle = 1'h0;
    action_done = 1'h0;
    tk(2);
  endtask
  initial begin
    #3000000;
    n_fail++;
    $display("BAD timeout exp done got hang");
    print_verdict();
  end
  initial begin
    {sys_rst, eeprom_busy, eeprom_we, demap_mode} = 4'h8;
    {system_clock_locked, phase_detector_cycle, action_done} = 3'h0;
    {eeprom_addr, eeprom_wdata, selected_ref} = 26'h0000001;
    {n_fail, cmp_count} = '0;
    st = 32'h7f08ea69;
    repeat (8) @(posedge clk_sys);
    tk(1);
    sys_rst = 1'h0;
    tk(4);
    chk("reset active", 8'h00, {7'h00, |active_regs});
    i2cbr_master_i.start();
    i2cbr_master_i.wbyte({~SA, 1'h0}, k);
    chk("ack foreign", 8'h00, k);
    i2cbr_master_i.stop();
    for (int i = 0; i < 4; i++) begin
      st = lfsr(st);
      wd[i] = st[7:0];
      exp_q.push_back(wd[i]);
    end
    wr(16'h0100, 4);
    chk("unlock", 8'h01, lock_unlock);
    chk("loop unlock", 8'h01, lu_seen);
    chk("not active", 8'h00, active_regs[15:8]);
    rd(16'h0100, 4, 1'h1);
    wr(16'h0102, 0);
    exp_q.push_back(wd[2]);
    exp_q.push_back(wd[3]);
    rd(16'h0000, 2, 1'h0);
    strobe();
    for (int i = 0; i < 4; i++) chk("active", wd[i], active_regs[i*8 +: 8]);
    chk("unlock strobe", 8'h00, lock_unlock);
    chk("holdover", 8'h01, holdover);
    pulse(0);
    chk("holdover end", 8'h00, holdover);
    system_clock_locked = 1'h1;
    wd = '{8'h3c, 8'h5a, 8'h66, 8'h00};
    wr(16'h0104, 3);
    chk("wdog hold", 8'h01, watchdog_hold);
    chk("stab run", 8'h00, stab_timer_run);
    chk("func stop", 8'h01, func_stop);
    strobe();
    chk("wdog run", 8'h00, watchdog_hold);
    chk("stab resume", 8'h01, stab_timer_run);
    chk("func start", 8'h00, func_stop);
    st = lfsr(st);
    wd[0] = st[7:0];
    wr(16'h0108, 1);
    tk(1);
    chk("live", wd[0], active_regs[71:64]);
    wd[0] = 8'h01;
    wr(16'h0109, 1);
    strobe();
    chk("autoclear set", 8'h01, active_regs[79:72]);
    pulse(1);
    chk("autoclear done", 8'h00, active_regs[79:72]);
    demap_mode = 1'h1;
    wd[0] = 8'h77;
    wr(16'h0107, 1);
    strobe();
    chk("demap holdover", 8'h01, holdover);
    pulse(0);
    wd[0] = 8'h99;
    wr(16'h1789, 1);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    rd(16'h1789, 1, 1'h1);
    rd(ADDR_STROBE, 1, 1'h1);
    eeprom_busy = 1'h1;
    wd[0] = 8'hc3;
    wr(16'h0103, 1);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h30);
    rd(16'h0103, 1, 1'h1);
    rd(16'h0d00, 1, 1'h1);
    for (int i = 0; i < 2; i++) begin
      eeprom_addr = i ? 16'h0100 : 16'h0103;
      eeprom_wdata = i ? 8'haa : 8'h5c;
      eeprom_we = 1'h1;
      tk(1);
      eeprom_we = 1'h0;
      tk(2);
      chk("eeprom read", i ? 8'h00 : 8'h5c, eeprom_rdata);
    end
    eeprom_addr = 16'h0d00;
    tk(2);
    chk("eeprom ro", 8'h00, eeprom_rdata);
    eeprom_busy = 1'h0;
    exp_q.push_back(8'h5c);
    rd(16'h0103, 1, 1'h1);
    tk(20);
    chk("queue left", 8'h00, 8'(exp_q.size()));
    chk("sda out", 8'h00, {7'h00, sda_out});
    print_verdict();
  end
endmodule
